// >>> rtl/codec_pin_function_mux.sv
// Purpose: Digital pin function multiplexer and clock source selection.
// Assumes: Configuration arrives on cfg_in, taken when cfg_load is high.
// Notes: Clock pins are sampled at clk, so clocks selected from pins are filtered levels; the PLL clock is passed unfiltered.
//
// Behaviour
// R1: Protocol select pin picks I2C or SPI.
// R2: Reset and protocol select are not reassignable.
// R3: Other pins power up default, then reprogrammable.
// R4: PLL reference from four selectable pins.
// R5: Codec clock from pins or PLL; master default.
// R6: Far side keeps PLL reference 512kHz to 50MHz.
// R7: Far side avoids PLL for lowest power.
// R8: General output on pins 2, 4, 5.
// R9: General input on pins 1, 3, 5.
// R10: Master and bit clock feed both at once.
// R11: Pin 5 as output never carries interrupt.
// R12: Bit and word clocks default in, switchable.

`timescale 1ns/1ns
`default_nettype none

module codec_pin_function_mux (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cfg_load,
    input wire codec_pin_pkg::pin_cfg_t cfg_in,
    output var codec_pin_pkg::pin_cfg_t cfg_now,
    input wire logic spi_select_pin,
    input wire logic mclk_pin,
    input wire logic bclk_i,
    output logic bclk_o,
    output logic bclk_oe,
    input wire logic wclk_i,
    output logic wclk_o,
    output logic wclk_oe,
    input wire logic multifunction_pin_1,
    output logic multifunction_pin_2_o,
    output logic multifunction_pin_2_oe,
    input wire logic multifunction_pin_3,
    output logic multifunction_pin_4_o,
    output logic multifunction_pin_4_oe,
    input wire logic multifunction_pin_5_i,
    output logic multifunction_pin_5_o,
    output logic multifunction_pin_5_oe,
    input wire codec_pin_pkg::core_out_t core_out,
    output var codec_pin_pkg::core_in_t core_in
);

    ////////////////////////////////////////////////////////////////////////
    // Pin input filtering

    logic [codec_pin_pkg::LV_WIDTH-1:0] pins_raw;
    logic [codec_pin_pkg::LV_WIDTH-1:0] lvl;

    assign pins_raw = {spi_select_pin, multifunction_pin_5_i, multifunction_pin_3,
                       multifunction_pin_1, wclk_i, bclk_i, mclk_pin};

    pin_sync #(
        .W(codec_pin_pkg::LV_WIDTH)
    ) pin_sync_i (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in(pins_raw),
        .level(lvl)
    );

    wire logic lv_mclk = lvl[codec_pin_pkg::LV_MCLK];
    wire logic lv_bclk = lvl[codec_pin_pkg::LV_BCLK];
    wire logic lv_wclk = lvl[codec_pin_pkg::LV_WCLK];
    wire logic lv_multifunction_pin_1 = lvl[codec_pin_pkg::LV_MULTIFUNCTION_PIN_1];
    wire logic lv_multifunction_pin_3 = lvl[codec_pin_pkg::LV_MULTIFUNCTION_PIN_3];
    wire logic lv_multifunction_pin_5 = lvl[codec_pin_pkg::LV_MULTIFUNCTION_PIN_5];
    wire logic lv_spi = lvl[codec_pin_pkg::LV_SPI];

    ////////////////////////////////////////////////////////////////////////
    // Configuration store

    codec_pin_pkg::pin_cfg_t cfg_r;
    codec_pin_pkg::pin_cfg_t cfg_nxt;

    // Protocol select and reset have no field here, so never remapped
    assign cfg_nxt = cfg_load ? cfg_in : cfg_r; // see R2 see R3

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_r <= codec_pin_pkg::CFG_RESET; // see R3 see R12
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    assign cfg_now = cfg_r;

    ////////////////////////////////////////////////////////////////////////
    // Clock source selection

    // Same pin may feed both selectors in the same cycle
    wire logic pll_ref_nxt =
        (cfg_r.pll_src == codec_pin_pkg::PLL_SRC_MCLK) ? lv_mclk :
        (cfg_r.pll_src == codec_pin_pkg::PLL_SRC_BCLK) ? lv_bclk :
        (cfg_r.pll_src == codec_pin_pkg::PLL_SRC_MULTIFUNCTION_PIN_5) ? lv_multifunction_pin_5 : lv_multifunction_pin_1; // see R4 see R10

    // PLL path kept available; choosing it costs power
    wire logic codec_clk_nxt =
        (cfg_r.codec_src == codec_pin_pkg::CODEC_SRC_MCLK) ? lv_mclk :
        (cfg_r.codec_src == codec_pin_pkg::CODEC_SRC_BCLK) ? lv_bclk :
        (cfg_r.codec_src == codec_pin_pkg::CODEC_SRC_MULTIFUNCTION_PIN_5) ? lv_multifunction_pin_5 :
        core_out.pll_clk; // see R5 see R10

    ////////////////////////////////////////////////////////////////////////
    // Output pin selection

    wire logic p2_gpo = cfg_r.multifunction_pin_2_fn == codec_pin_pkg::FN_GPO;
    wire logic p4_gpo = cfg_r.multifunction_pin_4_fn == codec_pin_pkg::FN_GPO;
    wire logic p5_gpo = cfg_r.multifunction_pin_5_fn == codec_pin_pkg::FN_GPO;

    wire logic p2_o_nxt = p2_gpo ? cfg_r.gpo[0] :
        (cfg_r.multifunction_pin_2_fn == codec_pin_pkg::FN_FIRST_INTERRUPT_OUTPUT) ? core_out.first_interrupt_output : core_out.dout; // see R8
    wire logic p2_oe_nxt = cfg_r.multifunction_pin_2_fn != codec_pin_pkg::FN_OFF;

    wire logic p4_o_nxt = p4_gpo ? cfg_r.gpo[1] :
        (cfg_r.multifunction_pin_4_fn == codec_pin_pkg::FN_FIRST_INTERRUPT_OUTPUT) ? core_out.first_interrupt_output : core_out.dmic_clk; // see R8
    wire logic p4_oe_nxt = cfg_r.multifunction_pin_4_fn != codec_pin_pkg::FN_OFF;

    // Output value wins outright; interrupt only when not an output
    wire logic p5_o_nxt = p5_gpo ? cfg_r.gpo[2] : core_out.first_interrupt_output; // see R8 see R11
    wire logic p5_oe_nxt = p5_gpo || (cfg_r.multifunction_pin_5_fn == codec_pin_pkg::FN_FIRST_INTERRUPT_OUTPUT);

    wire logic bclk_in_sel = cfg_r.bclk_out ? core_out.bclk : lv_bclk; // see R12
    wire logic wclk_in_sel = cfg_r.wclk_out ? core_out.wclk : lv_wclk; // see R12

    // Pin 5 reads as input only while the device is not driving it
    wire logic gpi5_nxt = p5_oe_nxt ? 1'b0 : lv_multifunction_pin_5;

    codec_pin_pkg::core_in_t core_in_nxt;

    assign core_in_nxt = '{
        pll_ref: pll_ref_nxt,
        codec_clk: codec_clk_nxt,
        bclk: bclk_in_sel,
        wclk: wclk_in_sel,
        din: lv_multifunction_pin_1,
        dmic_data: lv_multifunction_pin_3,
        gpi: {gpi5_nxt, lv_multifunction_pin_3, lv_multifunction_pin_1}, // see R9
        ctrl_spi: lv_spi // see R1 see R2
    };

    ////////////////////////////////////////////////////////////////////////
    // Output registers

    codec_pin_pkg::core_in_t core_in_r;
    logic [7:0] pin_o_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            core_in_r <= '0;
            pin_o_r <= 8'h00;
        end else begin
            core_in_r <= core_in_nxt;
            pin_o_r <= {core_out.bclk, cfg_r.bclk_out, core_out.wclk, cfg_r.wclk_out,
                        p2_o_nxt, p4_o_nxt, p5_o_nxt, p5_oe_nxt};
        end
    end

    logic [1:0] oe24_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oe24_r <= 2'h0;
        end else begin
            oe24_r <= {p2_oe_nxt, p4_oe_nxt};
        end
    end

    assign core_in = core_in_r;
    assign bclk_o = pin_o_r[7];
    assign bclk_oe = pin_o_r[6];
    assign wclk_o = pin_o_r[5];
    assign wclk_oe = pin_o_r[4];
    assign multifunction_pin_2_o = pin_o_r[3];
    assign multifunction_pin_4_o = pin_o_r[2];
    assign multifunction_pin_5_o = pin_o_r[1];
    assign multifunction_pin_5_oe = pin_o_r[0];
    assign multifunction_pin_2_oe = oe24_r[1];
    assign multifunction_pin_4_oe = oe24_r[0];

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_ctrl_protocol: assert property ( // see R1
        ##1 core_in.ctrl_spi == $past(lv_spi))
        else $error("protocol mode does not follow select pin");

    a_cfg_power_up: assert property (disable iff (1'b0) // see R3
        sys_rst |=> cfg_now == codec_pin_pkg::CFG_RESET)
        else $error("configuration not at default after reset");

    a_pll_ref_sel: assert property ( // see R4
        cfg_now.pll_src == codec_pin_pkg::PLL_SRC_MULTIFUNCTION_PIN_1 && !cfg_load
        |=> core_in.pll_ref == $past(lv_multifunction_pin_1))
        else $error("PLL reference not taken from pin 1");

    a_codec_clk_pll: assert property ( // see R5
        cfg_now.codec_src == codec_pin_pkg::CODEC_SRC_PLL
        |=> core_in.codec_clk == $past(core_out.pll_clk))
        else $error("codec clock not taken from PLL");

    a_shared_source: assert property ( // see R10
        cfg_now.pll_src == codec_pin_pkg::PLL_SRC_BCLK &&
        cfg_now.codec_src == codec_pin_pkg::CODEC_SRC_BCLK
        |=> core_in.pll_ref == core_in.codec_clk && core_in.codec_clk == $past(lv_bclk))
        else $error("bit clock not shared by both selectors");

    a_gpo_pin4: assert property ( // see R8
        cfg_now.multifunction_pin_4_fn == codec_pin_pkg::FN_GPO
        |=> multifunction_pin_4_oe && multifunction_pin_4_o == $past(cfg_now.gpo[1]))
        else $error("pin 4 output value wrong");

    a_pin5_no_int: assert property ( // see R11
        cfg_now.multifunction_pin_5_fn == codec_pin_pkg::FN_GPO
        |=> multifunction_pin_5_oe && multifunction_pin_5_o == $past(cfg_now.gpo[2]))
        else $error("pin 5 carries interrupt while an output");

    a_gpi_pin3: assert property ( // see R9
        ##1 core_in.gpi[1] == $past(lv_multifunction_pin_3))
        else $error("pin 3 input level wrong");

    a_bclk_dir: assert property ( // see R12
        !cfg_now.bclk_out |=> !bclk_oe ##0 core_in.bclk == $past(lv_bclk))
        else $error("bit clock driven while input");

    c_pll_on_multifunction_pin_5: cover property (cfg_now.pll_src == codec_pin_pkg::PLL_SRC_MULTIFUNCTION_PIN_5);
    c_codec_on_pll: cover property (cfg_now.codec_src == codec_pin_pkg::CODEC_SRC_PLL);
    c_pin5_gpo: cover property (cfg_now.multifunction_pin_5_fn == codec_pin_pkg::FN_GPO ##1 multifunction_pin_5_oe);
    c_spi_mode: cover property (core_in.ctrl_spi);

endmodule : codec_pin_function_mux

`default_nettype wire

// >>> rtl/pin_sync.sv
// Purpose: Package for the pin multiplexer, plus a three-stage pin input filter.
// Assumes: Pins are asynchronous to clk; one clk domain only.
// Notes: A filtered level changes only once the second and third stages agree.

`timescale 1ns/1ns
`default_nettype none

package codec_pin_pkg;

    // Pin level vector positions
    localparam int unsigned LV_MCLK = 0;
    localparam int unsigned LV_BCLK = 1;
    localparam int unsigned LV_WCLK = 2;
    localparam int unsigned LV_MULTIFUNCTION_PIN_1 = 3;
    localparam int unsigned LV_MULTIFUNCTION_PIN_3 = 4;
    localparam int unsigned LV_MULTIFUNCTION_PIN_5 = 5;
    localparam int unsigned LV_SPI = 6;
    localparam int unsigned LV_WIDTH = 7;

    // Reference clock sources for the PLL
    localparam logic [1:0] PLL_SRC_MCLK = 2'h0;
    localparam logic [1:0] PLL_SRC_BCLK = 2'h1;
    localparam logic [1:0] PLL_SRC_MULTIFUNCTION_PIN_5 = 2'h2;
    localparam logic [1:0] PLL_SRC_MULTIFUNCTION_PIN_1 = 2'h3;

    // Codec clock sources
    localparam logic [1:0] CODEC_SRC_MCLK = 2'h0;
    localparam logic [1:0] CODEC_SRC_BCLK = 2'h1;
    localparam logic [1:0] CODEC_SRC_MULTIFUNCTION_PIN_5 = 2'h2;
    localparam logic [1:0] CODEC_SRC_PLL = 2'h3;

    // Output-capable pin functions
    localparam logic [1:0] FN_DEFAULT = 2'h0;
    localparam logic [1:0] FN_GPO = 2'h1;
    localparam logic [1:0] FN_FIRST_INTERRUPT_OUTPUT = 2'h2;
    localparam logic [1:0] FN_OFF = 2'h3;

    typedef struct packed {
        logic [1:0] pll_src;
        logic [1:0] codec_src;
        logic bclk_out;
        logic wclk_out;
        logic [1:0] multifunction_pin_2_fn;
        logic [1:0] multifunction_pin_4_fn;
        logic [1:0] multifunction_pin_5_fn;
        logic [2:0] gpo;
    } pin_cfg_t;

    // Power-up functions: codec clock on the master clock, serial clocks in,
    // data out on pin 2, mic clock on pin 4, pin 5 as plain input
    localparam pin_cfg_t CFG_RESET = '{
        pll_src: 2'h0,
        codec_src: 2'h0,
        bclk_out: 1'b0,
        wclk_out: 1'b0,
        multifunction_pin_2_fn: 2'h0,
        multifunction_pin_4_fn: 2'h0,
        multifunction_pin_5_fn: 2'h0,
        gpo: 3'h0
    };

    typedef struct packed {
        logic dout;
        logic bclk;
        logic wclk;
        logic dmic_clk;
        logic first_interrupt_output;
        logic pll_clk;
    } core_out_t;

    typedef struct packed {
        logic pll_ref;
        logic codec_clk;
        logic bclk;
        logic wclk;
        logic din;
        logic dmic_data;
        logic [2:0] gpi;
        logic ctrl_spi;
    } core_in_t;

endpackage : codec_pin_pkg

module pin_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] level_r;
    wire logic [W-1:0] agree = ~(s2_r ^ s3_r);
    wire logic [W-1:0] level_nxt = (agree & s3_r) | (~agree & level_r);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            level_r <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign level = level_r;

endmodule : pin_sync

`default_nettype wire

// >>> tb/codec_pin_partner.sv
// Purpose: Far-side model: master clock source and host levels on the pins.
// Assumes: Levels come from the bench; a driving device wins on its pins.
// Notes: Master clock toggles every 8 cycles when running (15.6 MHz).
`timescale 1ns/1ns
`default_nettype none

module codec_pin_partner (
    input wire logic clk,
    input wire logic mclk_run,
    input wire logic [5:0] lvl,
    input wire logic bclk_o,
    input wire logic bclk_oe,
    input wire logic wclk_o,
    input wire logic wclk_oe,
    input wire logic p5_o,
    input wire logic p5_oe,
    output logic mclk_pin,
    output logic bclk_i,
    output logic wclk_i,
    output logic p1,
    output logic p3,
    output logic p5_i
);
    logic [2:0] div_r = 3'h0;
    logic mclk_r = 1'b0;

    // Reference kept well inside the accepted band
    always_ff @(posedge clk) begin
        div_r <= div_r + 3'h1;
        if (div_r == 3'h7) mclk_r <= ~mclk_r;
    end

    // Lowest-power case: the model never asks for the PLL on its own
    assign mclk_pin = mclk_run ? mclk_r : lvl[0];
    assign bclk_i = bclk_oe ? bclk_o : lvl[1];
    assign wclk_i = wclk_oe ? wclk_o : lvl[2];
    assign p1 = lvl[3];
    assign p3 = lvl[4];
    assign p5_i = p5_oe ? p5_o : lvl[5];
endmodule : codec_pin_partner
`default_nettype wire

// >>> tb/codec_pin_function_mux_bench.sv
// Purpose: Self-checking bench for the pin function multiplexer.
// Assumes: Pin inputs settle within 8 cycles, config within 4.
// Notes: No handshakes; fixed waits follow the hand-over latencies.
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end

module codec_pin_function_mux_bench;
    logic clk = 1'b0, sys_rst = 1'b1, cfg_load = 1'b0, spi_select_pin = 1'b0, mclk_run = 1'b0;
    logic [5:0] lvl = 6'h0;
    codec_pin_pkg::pin_cfg_t cfg_in = codec_pin_pkg::CFG_RESET, cfg_now, c;
    codec_pin_pkg::core_out_t core_out = '0;
    codec_pin_pkg::core_in_t core_in;
    logic mclk_pin, bclk_i, bclk_o, bclk_oe, wclk_i, wclk_o, wclk_oe, p1, p3, p5_i;
    logic p2_o, p2_oe, p4_o, p4_oe, p5_o, p5_oe;
    int n_fail = 0, samples_checked = 0, tog;

    codec_pin_function_mux codec_pin_function_mux_i (.clk(clk), .sys_rst(sys_rst),
        .cfg_load(cfg_load), .cfg_in(cfg_in), .cfg_now(cfg_now),
        .spi_select_pin(spi_select_pin), .mclk_pin(mclk_pin), .bclk_i(bclk_i),
        .bclk_o(bclk_o), .bclk_oe(bclk_oe), .wclk_i(wclk_i), .wclk_o(wclk_o),
        .wclk_oe(wclk_oe), .multifunction_pin_1(p1), .multifunction_pin_2_o(p2_o),
        .multifunction_pin_2_oe(p2_oe), .multifunction_pin_3(p3),
        .multifunction_pin_4_o(p4_o), .multifunction_pin_4_oe(p4_oe),
        .multifunction_pin_5_i(p5_i), .multifunction_pin_5_o(p5_o),
        .multifunction_pin_5_oe(p5_oe), .core_out(core_out), .core_in(core_in));
    codec_pin_partner codec_pin_partner_i (.clk(clk), .mclk_run(mclk_run), .lvl(lvl),
        .bclk_o(bclk_o), .bclk_oe(bclk_oe), .wclk_o(wclk_o), .wclk_oe(wclk_oe),
        .p5_o(p5_o), .p5_oe(p5_oe), .mclk_pin(mclk_pin), .bclk_i(bclk_i),
        .wclk_i(wclk_i), .p1(p1), .p3(p3), .p5_i(p5_i));

    initial begin
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic load(input codec_pin_pkg::pin_cfg_t v);
        @(posedge clk) begin cfg_in <= v; cfg_load <= 1'b1; end
        @(posedge clk) cfg_load <= 1'b0;
        step(4);
    endtask : load

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK("cfg_now", codec_pin_pkg::CFG_RESET, cfg_now)
        `CHK("serial oe", 2'h0, {bclk_oe, wclk_oe})
        `CHK("pin5 oe", 1'b0, p5_oe)
    endtask : t_reset

    task automatic t_proto();
        @(posedge clk) spi_select_pin <= 1'b1;
        step(8);
        `CHK("ctrl_spi", 1'b1, core_in.ctrl_spi)
        load('1);
        `CHK("ctrl_spi fixed", 1'b1, core_in.ctrl_spi)
        @(posedge clk) spi_select_pin <= 1'b0;
        step(8);
        `CHK("ctrl_i2c", 1'b0, core_in.ctrl_spi)
    endtask : t_proto

    task automatic t_pll();
        int pos[4] = '{0, 1, 5, 3};
        for (int i = 0; i < 4; i++) begin
            c = codec_pin_pkg::CFG_RESET;
            c.pll_src = 2'(i);
            load(c);
            @(posedge clk) lvl <= 6'h1 << pos[i];
            step(8);
            `CHK("pll_ref hi", 1'b1, core_in.pll_ref)
            @(posedge clk) lvl <= ~(6'h1 << pos[i]);
            step(8);
            `CHK("pll_ref lo", 1'b0, core_in.pll_ref)
        end
    endtask : t_pll

    task automatic t_codec();
        int pos[3] = '{0, 1, 5};
        for (int i = 0; i < 3; i++) begin
            c = codec_pin_pkg::CFG_RESET;
            c.codec_src = 2'(i);
            load(c);
            @(posedge clk) lvl <= 6'h1 << pos[i];
            step(8);
            `CHK("codec_clk hi", 1'b1, core_in.codec_clk)
            @(posedge clk) lvl <= ~(6'h1 << pos[i]);
            step(8);
            `CHK("codec_clk lo", 1'b0, core_in.codec_clk)
        end
        c.codec_src = codec_pin_pkg::CODEC_SRC_PLL;
        load(c);
        @(posedge clk) core_out.pll_clk <= 1'b1;
        step(3);
        `CHK("codec from pll", 1'b1, core_in.codec_clk)
        @(posedge clk) core_out.pll_clk <= 1'b0;
        step(3);
        `CHK("codec from pll", 1'b0, core_in.codec_clk)
    endtask : t_codec

    task automatic t_both();
        load(codec_pin_pkg::CFG_RESET);
        @(posedge clk) mclk_run <= 1'b1;
        step(8);
        tog = 0;
        for (int i = 0; i < 40; i++) begin
            step(1);
            `CHK("mclk shared", core_in.pll_ref, core_in.codec_clk)
            if (core_in.pll_ref !== core_in.codec_clk) tog = tog - 100;
            if (core_in.pll_ref === 1'b1) tog++;
        end
        `CHK("mclk toggles", 1'b1, (tog > 8 && tog < 32))
        @(posedge clk) mclk_run <= 1'b0;
        c = codec_pin_pkg::CFG_RESET;
        c.pll_src = codec_pin_pkg::PLL_SRC_BCLK;
        c.codec_src = codec_pin_pkg::CODEC_SRC_BCLK;
        load(c);
        @(posedge clk) lvl <= 6'h02;
        step(8);
        `CHK("bclk shared hi", 2'h3, {core_in.pll_ref, core_in.codec_clk})
        @(posedge clk) lvl <= 6'h3d;
        step(8);
        `CHK("bclk shared lo", 2'h0, {core_in.pll_ref, core_in.codec_clk})
    endtask : t_both

    task automatic t_gpo();
        c = codec_pin_pkg::CFG_RESET;
        c.multifunction_pin_2_fn = codec_pin_pkg::FN_GPO;
        c.multifunction_pin_4_fn = codec_pin_pkg::FN_GPO;
        c.multifunction_pin_5_fn = codec_pin_pkg::FN_GPO;
        c.gpo = 3'h5;
        @(posedge clk) core_out <= '1;
        load(c);
        `CHK("gpo 101", 6'h37, {p2_o, p2_oe, p4_o, p4_oe, p5_o, p5_oe})
        c.gpo = 3'h2;
        load(c);
        `CHK("gpo 010", 6'h1d, {p2_o, p2_oe, p4_o, p4_oe, p5_o, p5_oe})
        `CHK("pin5 no int", 1'b0, p5_o)
        c.multifunction_pin_2_fn = codec_pin_pkg::FN_FIRST_INTERRUPT_OUTPUT;
        c.multifunction_pin_4_fn = codec_pin_pkg::FN_OFF;
        c.multifunction_pin_5_fn = codec_pin_pkg::FN_FIRST_INTERRUPT_OUTPUT;
        load(c);
        `CHK("int and off", 6'h3b, {p2_o, p2_oe, p4_o, p4_oe, p5_o, p5_oe})
        load(codec_pin_pkg::CFG_RESET);
        `CHK("default fn", 5'h1e, {p2_o, p2_oe, p4_o, p4_oe, p5_oe})
        @(posedge clk) core_out <= '0;
    endtask : t_gpo

    task automatic t_gpi();
        logic [2:0] pat[4] = '{3'h1, 3'h2, 3'h4, 3'h0};
        load(codec_pin_pkg::CFG_RESET);
        foreach (pat[i]) begin
            @(posedge clk) lvl <= {pat[i], 3'h0};
            step(8);
            `CHK("gpi", pat[i], core_in.gpi)
            `CHK("din dmic", pat[i][1:0], {core_in.dmic_data, core_in.din})
        end
    endtask : t_gpi

    task automatic t_serial();
        c = codec_pin_pkg::CFG_RESET;
        c.bclk_out = 1'b1;
        @(posedge clk) core_out <= '{bclk: 1'b1, wclk: 1'b1, default: 1'b0};
        load(c);
        `CHK("bclk out", 4'hd, {bclk_o, bclk_oe, wclk_oe, core_in.bclk})
        c.bclk_out = 1'b0;
        c.wclk_out = 1'b1;
        load(c);
        `CHK("wclk out", 4'h7, {bclk_oe, wclk_o, wclk_oe, core_in.wclk})
        @(posedge clk) sys_rst <= 1'b1;
        step(4);
        @(posedge clk) sys_rst <= 1'b0;
        step(1);
        `CHK("second reset", codec_pin_pkg::CFG_RESET, cfg_now)
        `CHK("reset serial oe", 2'h0, {bclk_oe, wclk_oe})
    endtask : t_serial

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        step(1);
        t_reset();
        t_proto();
        t_pll();
        t_codec();
        t_both();
        t_gpo();
        t_gpi();
        t_serial();
        results();
    end

    // Watchdog in case a step never returns
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        results();
    end
endmodule : codec_pin_function_mux_bench
`default_nettype wire
